// ===== design/hic_regs.v
// Host-side control registers: interrupt masks, byte-order probe, FIFO
// level thresholds and receive configuration, reached over AHB-Lite.
// Assumes event, level and strobe inputs come from logic on mclk.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "hic_defines.vh"

// What this block does
// - Enable bits gate sources; reset zero
// - Status captures events regardless of enables
// - Bits 31,25,24,23 enabled; 30-26,22 reserved
// - Bits 21 to 16 mask listed sources
// - Bits 15-13 mask; bit 12 reserved
// - Bits 11-0 mask FIFO and pin sources
// - Probe register always reads fixed pattern
// - TX free blocks above threshold flags
// - TX status occupancy above threshold flags
// - RX free blocks below threshold flags
// - RX status occupancy above threshold flags
// - Pad last buffer transfer to alignment
// - Countdown decrements per word, holds at zero; done raises interrupt
// - New count write replaces remaining count
// - Dump bit flushes RX FIFOs, self-clears
// - Start of data shifted 0-31 bytes
// - Word offset changes apply at next read or flush
// - Countdown completion sets status bit 20
module hic_regs #(
   parameter LVL_W = 8,
   parameter CNT_W = 12
) (
   input  wire             mclk,
   input  wire             rst,
   input  wire             ce,
   input  wire             hsel,
   input  wire [7:0]       haddr,
   input  wire [1:0]       htrans,
   input  wire             hwrite,
   input  wire [2:0]       hsize,
   input  wire [31:0]      hwdata,
   input  wire             hready,
   output reg              hreadyout,
   output reg  [31:0]      hrdata,
   output reg              hresp,
   input  wire [31:0]      irq_src_evt,
   input  wire [LVL_W-1:0] tx_data_free_blk,
   input  wire [LVL_W-1:0] tx_stat_used,
   input  wire [LVL_W-1:0] rx_data_free_blk,
   input  wire [LVL_W-1:0] rx_stat_used,
   input  wire             rx_fifo_rd,
   input  wire             rx_buf_last,
   output reg              irq_q,
   output reg              rx_flush_q,
   output reg              rx_pad_valid_q,
   output reg  [2:0]       rx_pad_dwords_q,
   output reg  [2:0]       rx_dword_offset_q,
   output reg  [1:0]       rx_byte_offset_q
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   reg [31:0]      status_q;
   reg [31:0]      enable_q;
   reg [31:0]      fifolvl_q;
   reg [1:0]       align_q;
   reg [CNT_W-1:0] rx_dword_countdown_q;
   reg [4:0]       rx_start_offset_q;
   reg [2:0]       buf_cnt_q;
   reg             wr_pend_q;
   reg             rd_pend_q;
   reg [7:0]       addr_q;

   wire            req;
   wire            do_wr;
   wire [31:0]     evt_all;
   wire            cnt_done;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Pad words so that the word count n lands on the chosen boundary
   function [2:0] pad_words;
      input [1:0] align;
      input [2:0] n;
      reg   [2:0] mask;
      begin
         mask = 3'h0;
         case (align)
            `HIC_ALIGN_16: mask = 3'h3;
            `HIC_ALIGN_32: mask = 3'h7;
            default:       mask = 3'h0; // 4-byte and reserved: no pad
         endcase
         pad_words = (3'h0 - n) & mask;
      end
   endfunction

   // Register read multiplexer; reserved and unmapped read as zero
   function [31:0] rd_mux;
      input [7:0] a;
      begin
         case (a)
            `HIC_OFS_STATUS:  rd_mux = status_q;
            `HIC_OFS_ENABLE:  rd_mux = enable_q;
            `HIC_OFS_PROBE:   rd_mux = `HIC_PROBE_VALUE;
            `HIC_OFS_FIFOLVL: rd_mux = fifolvl_q;
            `HIC_OFS_RXCFG:   rd_mux = {align_q, 2'h0,
                                        rx_dword_countdown_q, 3'h0,
                                        rx_start_offset_q, 8'h00};
            default:          rd_mux = 32'h00000000;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------------
   assign req   = hsel & hready & (htrans == `HIC_HTRANS_NSEQ ||
                                   htrans == `HIC_HTRANS_SEQ);
   assign do_wr = ce & wr_pend_q;

   // Reads take one wait state so a write just before is always seen
   always @(posedge mclk) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hrdata    <= 32'h00000000;
         hresp     <= 1'b0;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else if (ce) begin
         hresp <= 1'b0;
         if (rd_pend_q) begin
            hrdata    <= rd_mux(addr_q);
            hreadyout <= 1'b1;
            rd_pend_q <= 1'b0;
         end else begin
            wr_pend_q <= req & hwrite;
            rd_pend_q <= req & ~hwrite;
            hreadyout <= ~(req & ~hwrite);
            if (req) begin
               addr_q <= haddr;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Event gathering
   // ----------------------------------------------------------------------
   // Datapath events plus threshold and countdown flags of this block
   assign cnt_done = rx_fifo_rd && rx_dword_countdown_q == {{(CNT_W-1){1'b0}}, 1'b1};

   assign evt_all = (irq_src_evt
      | ({31'h0, cnt_done} << `HIC_BIT_RXDMA)
      | ({31'h0, tx_data_free_blk > fifolvl_q[`HIC_TXAV_HI:`HIC_TXAV_LO]}
         << `HIC_BIT_TXAVAIL)
      | ({31'h0, tx_stat_used > fifolvl_q[`HIC_TXSL_HI:`HIC_TXSL_LO]}
         << `HIC_BIT_TXSLVL)
      | ({31'h0, rx_data_free_blk < fifolvl_q[`HIC_RXDL_HI:`HIC_RXDL_LO]}
         << `HIC_BIT_RXDLVL)
      | ({31'h0, rx_stat_used > fifolvl_q[`HIC_RXSL_HI:`HIC_RXSL_LO]}
         << `HIC_BIT_RXSLVL))
      & `HIC_IRQ_BITS;

   // ----------------------------------------------------------------------
   // Status and enables
   // ----------------------------------------------------------------------
   // Status latches every event, masked or not; a new event beats a clear
   always @(posedge mclk) begin
      if (rst) begin
         status_q <= 32'h00000000;
      end else if (ce) begin
         status_q <= (status_q & ~((do_wr && addr_q == `HIC_OFS_STATUS) ?
                                   hwdata : 32'h00000000))
                     | evt_all;
      end
   end

   // Only documented enable bits store; reserved bits stay zero
   always @(posedge mclk) begin
      if (rst) begin
         enable_q  <= `HIC_ENABLE_RST;
         fifolvl_q <= `HIC_FIFOLVL_RST;
      end else if (ce && do_wr) begin
         if (addr_q == `HIC_OFS_ENABLE) begin
            enable_q <= hwdata & `HIC_IRQ_BITS;
         end
         if (addr_q == `HIC_OFS_FIFOLVL) begin
            fifolvl_q <= hwdata;
         end
      end
   end

   // Single interrupt output, registered to keep it glitch free
   always @(posedge mclk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= |(status_q & enable_q);
      end
   end

   // ----------------------------------------------------------------------
   // Receive configuration
   // ----------------------------------------------------------------------
   // Countdown: a write replaces it, otherwise each word read takes one until it reaches zero
   always @(posedge mclk) begin
      if (rst) begin
         align_q              <= 2'h0;
         rx_dword_countdown_q <= {CNT_W{1'b0}};
         rx_start_offset_q    <= 5'h00;
         rx_flush_q           <= 1'b0;
      end else if (ce) begin
         rx_flush_q <= 1'b0;
         if (do_wr && addr_q == `HIC_OFS_RXCFG) begin
            align_q              <= hwdata[`HIC_ALIGN_HI:`HIC_ALIGN_LO];
            rx_dword_countdown_q <= hwdata[`HIC_CNT_HI:`HIC_CNT_LO];
            rx_start_offset_q    <= hwdata[`HIC_OFFW_HI:`HIC_OFFB_LO];
            rx_flush_q           <= hwdata[`HIC_DUMP_BIT];
         end else if (rx_fifo_rd && rx_dword_countdown_q != {CNT_W{1'b0}}) begin
            rx_dword_countdown_q <= rx_dword_countdown_q - 1'b1;
         end
      end
   end

   // Applied offset: byte part follows directly (host changes it only
   // while halted); word part is taken up at the next word read or flush
   always @(posedge mclk) begin
      if (rst) begin
         rx_byte_offset_q  <= 2'h0;
         rx_dword_offset_q <= 3'h0;
      end else if (ce) begin
         rx_byte_offset_q <= rx_start_offset_q[1:0];
         if (rx_fifo_rd || rx_flush_q) begin
            rx_dword_offset_q <= rx_start_offset_q[4:2];
         end
      end
   end

   // ----------------------------------------------------------------------
   // End alignment padding
   // ----------------------------------------------------------------------
   // Words of the current buffer, modulo the largest boundary (8 words)
   always @(posedge mclk) begin
      if (rst) begin
         buf_cnt_q       <= 3'h0;
         rx_pad_valid_q  <= 1'b0;
         rx_pad_dwords_q <= 3'h0;
      end else if (ce) begin
         rx_pad_valid_q <= 1'b0;
         if (rx_flush_q) begin
            buf_cnt_q <= 3'h0;
         end else if (rx_fifo_rd) begin
            if (rx_buf_last) begin
               buf_cnt_q       <= 3'h0;
               rx_pad_valid_q  <= 1'b1;
               rx_pad_dwords_q <= pad_words(align_q, buf_cnt_q + 3'h1);
            end else begin
               buf_cnt_q <= buf_cnt_q + 3'h1;
            end
         end
      end
   end

endmodule

// ===== inc/hic_defines.vh
// Offsets, field positions, reset values and masks of the host control block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef HIC_DEFINES_VH
`define HIC_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define HIC_OFS_STATUS    8'h58
`define HIC_OFS_ENABLE    8'h5C
`define HIC_OFS_PROBE     8'h64
`define HIC_OFS_FIFOLVL   8'h68
`define HIC_OFS_RXCFG     8'h6C

// ----------------------------------------------------------------------
// Reset values and constant patterns
// ----------------------------------------------------------------------
`define HIC_PROBE_VALUE   32'h87654321
`define HIC_FIFOLVL_RST   32'h48000000
`define HIC_ENABLE_RST    32'h00000000
`define HIC_RXCFG_RST     32'h00000000
// Writable enable bits and clearable status bits (reserved bits excluded)
`define HIC_IRQ_BITS      32'h83BFEFFF

// ----------------------------------------------------------------------
// Interrupt bit positions driven by this block
// ----------------------------------------------------------------------
`define HIC_BIT_RXDMA     20
`define HIC_BIT_TXAVAIL   9
`define HIC_BIT_TXSLVL    7
`define HIC_BIT_RXDLVL    5
`define HIC_BIT_RXSLVL    3

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HIC_TXAV_HI       31
`define HIC_TXAV_LO       24
`define HIC_TXSL_HI       23
`define HIC_TXSL_LO       16
`define HIC_RXDL_HI       15
`define HIC_RXDL_LO       8
`define HIC_RXSL_HI       7
`define HIC_RXSL_LO       0
`define HIC_ALIGN_HI      31
`define HIC_ALIGN_LO      30
`define HIC_CNT_HI        27
`define HIC_CNT_LO        16
`define HIC_DUMP_BIT      15
`define HIC_OFFW_HI       12
`define HIC_OFFW_LO       10
`define HIC_OFFB_HI       9
`define HIC_OFFB_LO       8

// ----------------------------------------------------------------------
// End alignment codes
// ----------------------------------------------------------------------
`define HIC_ALIGN_4       2'h0
`define HIC_ALIGN_16      2'h1
`define HIC_ALIGN_32      2'h2

// AHB transfer type with a real request
`define HIC_HTRANS_NSEQ   2'h2
`define HIC_HTRANS_SEQ    2'h3

`endif

// ===== sim/hic_asserts.sv
// Port-level checks of the host control register block.
// Assumes hready is fed from hreadyout and ce stays high.
`timescale 1ns/1ns
module hic_asserts (
   input logic        mclk,
   input logic        rst,
   input logic        ce,
   input logic        hsel,
   input logic [7:0]  haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [31:0] hwdata,
   input logic        hready,
   input logic        hreadyout,
   input logic [31:0] hrdata,
   input logic [31:0] irq_src_evt,
   input logic        rx_fifo_rd,
   input logic        rx_buf_last,
   input logic        irq_q,
   input logic        rx_flush_q,
   input logic        rx_pad_valid_q,
   input logic [1:0]  rx_byte_offset_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst || !ce);
   logic        acc;
   logic        wp_q;
   logic [7:0]  a_q;
   logic [31:0] en_q;
   logic [1:0]  ob_q;
   // ------
   // Write mirror: data lands one edge after the address
   // ------
   assign acc = hsel && hready && htrans[1];
   always @(posedge mclk) begin
      if (rst) begin
         wp_q <= 1'b0;
         en_q <= 32'h0;
         ob_q <= 2'h0;
      end else begin
         wp_q <= acc && hwrite;
         a_q  <= haddr;
         if (wp_q && a_q == 8'h5C)
            en_q <= hwdata & 32'h83BFEFFF;
         if (wp_q && a_q == 8'h6C)
            ob_q <= hwdata[9:8];
      end
   end
   rd_wait_a: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   probe_read_a: assert property (acc && !hwrite && haddr == 8'h64 |-> ##2 hrdata == 32'h87654321)
      else $error("probe pattern wrong");
   irq_follow_a: assert property ((irq_src_evt & en_q) != 32'h0 && !wp_q |-> ##2 irq_q)
      else $error("enabled event gave no interrupt");
   mask_gates_a: assert property ($past(en_q) == 32'h0 |-> !irq_q)
      else $error("interrupt with all masks clear");
   flush_pulse_a: assert property (wp_q && a_q == 8'h6C && hwdata[15] |-> ##[1:2] rx_flush_q)
      else $error("flush not issued");
   pad_strobe_a: assert property (rx_fifo_rd && rx_buf_last |=> rx_pad_valid_q)
      else $error("pad strobe missing");
   pad_quiet_a: assert property (!(rx_fifo_rd && rx_buf_last) |=> !rx_pad_valid_q)
      else $error("pad strobe without last word");
   byte_offset_a: assert property (rx_byte_offset_q == $past(ob_q))
      else $error("byte offset not applied");
   cover property (rx_flush_q);
   cover property (irq_q);
   cover property (rx_pad_valid_q);
endmodule
bind hic_regs hic_asserts u_chk (.mclk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hreadyout, .hrdata, .irq_src_evt, .rx_fifo_rd, .rx_buf_last, .irq_q,
   .rx_flush_q, .rx_pad_valid_q, .rx_byte_offset_q);

// ===== sim/hic_host.sv
// Host processor model: single word transfers on AHB-Lite.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ns
module hic_host (
   input  logic        mclk,
   input  logic        hready,
   input  logic [31:0] hrdata,
   output logic        hsel,
   output logic [7:0]  haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [2:0]  hsize,
   output logic [31:0] hwdata
);
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
   end
   // ------
   // Each phase held until hready is seen high
   // ------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge mclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;  // Idle data never repeats the last word
   endtask
endmodule

// ===== sim/testbench.sv
// Bench for the host control registers: bus traffic and RX reads.
// Assumes the checker is bound into the register block.
`timescale 1ns/1ns
module testbench;
   localparam logic [31:0] LIVE = ~32'h7C401000;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        hready, hsel, hwrite, rd, last, irq, flush, padv, resp;
   logic [7:0]  haddr;
   logic [1:0]  htrans, bo;
   logic [2:0]  hsize, pad, dwo, pad_seen;
   logic [31:0] hwdata, hrdata, evt, q;
   logic [7:0]  lv [4] = '{8'h00, 8'h00, 8'hFF, 8'h00};
   int          mismatches = 0;
   int          check_count = 0;
   int          flushes = 0;
   int          i;
   always #5 mclk = ~mclk;
   hic_host host (.mclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
   hic_regs uut (.mclk, .rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout(hready), .hrdata, .hresp(resp), .irq_src_evt(evt),
      .tx_data_free_blk(lv[0]), .tx_stat_used(lv[1]), .rx_data_free_blk(lv[2]),
      .rx_stat_used(lv[3]), .rx_fifo_rd(rd), .rx_buf_last(last), .irq_q(irq),
      .rx_flush_q(flush), .rx_pad_valid_q(padv), .rx_pad_dwords_q(pad),
      .rx_dword_offset_q(dwo), .rx_byte_offset_q(bo));
   // Strobes last one cycle, so catch them here
   always @(posedge mclk) begin
      if (padv === 1'b1)
         pad_seen <= pad;
      if (flush === 1'b1)
         flushes <= flushes + 1;
   end
   // ------
   // Tasks
   // ------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic rdw(input int n, input logic l);
      for (int k = n; k > 0; k--) begin
         @(posedge mclk);
         rd   <= 1'b1;
         last <= l && k == 1;
      end
      @(posedge mclk);
      rd   <= 1'b0;
      last <= 1'b0;
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(posedge mclk);
      chk(irq, e);
   endtask
   task automatic lvl(input int b, input logic e);
      wr(8'h58, 32'hFFFFFFFF);
      wr(8'h5C, 32'h1 << b);
      irq_is(e);
      wr(8'h5C, 32'h0);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ------
   // Tests
   // ------
   initial begin
      {evt, rd, last} = '0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      rdc(8'h5C, 32'h0);
      rdc(8'h68, 32'h48000000);
      rdc(8'h70, 32'h0);
      chk(resp, 1'b0);
      wr(8'h64, 32'h0);
      rdc(8'h64, 32'h87654321);
      wr(8'h5C, 32'hFFFFFFFF);
      rdc(8'h5C, LIVE);
      // Every live source: kept while masked, passed once enabled; reserved bits stay quiet
      for (i = 0; i < 32; i++) begin
         wr(8'h5C, 32'h0);
         evt <= 32'h1 << i;
         @(posedge mclk);
         evt <= 32'h0;
         irq_is(1'b0);
         wr(8'h5C, 32'h1 << i);
         irq_is(LIVE[i]);
         // A fresh event while enabled, so the follow check sees traffic
         evt <= 32'h1 << i;
         @(posedge mclk);
         evt <= 32'h0;
         wr(8'h58, 32'hFFFFFFFF);
         irq_is(1'b0);
      end
      wr(8'h68, 32'h10203040);
      // Level equal to threshold is quiet, one step past it fires
      for (i = 0; i < 4; i++) begin
         lv[i] <= 8'(16 * i + 16);
         lvl(9 - 2 * i, 1'b0);
         lv[i] <= (i == 2) ? 8'h2F : 8'(16 * i + 17);
         lvl(9 - 2 * i, 1'b1);
         lv[i] <= (i == 2) ? 8'hFF : 8'h00;
      end
      wr(8'h5C, 32'h00100000);
      wr(8'h6C, 32'h00030000);
      rdw(2, 1'b0);
      rdc(8'h6C, 32'h00010000);
      wr(8'h6C, 32'h00050000);
      rdw(4, 1'b0);
      irq_is(1'b0);
      rdw(1, 1'b0);
      irq_is(1'b1);
      // Close the buffer left open by the countdown reads first
      rdw(1, 1'b1);
      // Alignment only changed between buffers; pad words never read
      for (i = 0; i < 4; i++) begin
         wr(8'h6C, 32'(i < 2 ? 1 - i : i) << 30);
         rdw(3, 1'b1);
         repeat (2) @(posedge mclk);
         chk(pad_seen, i == 0 ? 1 : i == 2 ? 5 : 0);
      end
      wr(8'h6C, 32'hFFFFFFFF);
      rdc(8'h6C, 32'hCFFF1F00);
      chk(flushes, 1);
      chk(dwo, 3'h7);
      // Receiver idle, so the byte part may change
      wr(8'h6C, 32'h00000900);
      chk(dwo, 3'h7);
      rdw(1, 1'b0);
      @(posedge mclk);
      chk(dwo, 3'h2);
      chk(bo, 2'h1);
      tally_and_finish;
   end
   // Whole run needs under a thousand cycles
   initial begin
      #200000;
      mismatches++;
      tally_and_finish;
   end
endmodule
